// ### rtl/pfb_pkg.sv
// Package of constants and types for the program fetch bus select block
// How it works
// - Strap low: extra ports behave as plain I/O, no bus function.
// - Strap low: every program fetch goes over the original port pair.
// - Strap high: extra ports form a multiplexed bus for program fetches only.
// - Alternate read strobe enables external program memory on the extra bus.
// - Alternate strobe pulses twice per machine cycle without data access.
// - Data access in a cycle drops the second alternate strobe pulse.
// - Data accesses never use the extra bus, always the original pair.
// - Strap high, access pin low: all fetches over extra bus, ordinary strobe idle.
// - Both high: below 2000H extra bus, 2000H and above original pair.
// - Extra bus fetch: high address byte on port 6, low byte on port 5.
// - Latch strobe pulses while low byte on port 5; opcode then sampled there.
// - Extra bus fetches use the same cycle timing as original pair fetches.
// - Port 5 register at 91H, port 6 at 0A1H, no single-bit addressing.
package pfb_pkg;

  localparam logic [7:0]  SFR_PORT5_ADDR  = 8'h91;
  localparam logic [7:0]  SFR_PORT6_ADDR  = 8'hA1;
  localparam logic [7:0]  PORT_RESET_VAL  = 8'hFF;
  localparam logic [15:0] SPLIT_ADDR      = 16'h2000;
  localparam logic [15:0] FULL_TOP_ADDR   = 16'hFFFF;

  // Machine cycle phases, one per core clock enable
  localparam logic [3:0]  PHASES_PER_MC   = 4'hC;
  localparam logic [3:0]  PH_ALE1_ON      = 4'h0;
  localparam logic [3:0]  PH_ALE1_OFF     = 4'h2;
  localparam logic [3:0]  PH_STB1_ON      = 4'h3;
  localparam logic [3:0]  PH_STB1_OFF     = 4'h5;
  localparam logic [3:0]  PH_ALE2_ON      = 4'h6;
  localparam logic [3:0]  PH_ALE2_OFF     = 4'h8;
  localparam logic [3:0]  PH_STB2_ON      = 4'h9;
  localparam logic [3:0]  PH_STB2_OFF     = 4'hB;
  localparam logic [3:0]  PH_LAST         = 4'hB;

  // Core clock enable divider: 25 MHz down to one phase per 2 cycles
  localparam logic [3:0]  PHASE_DIV       = 4'h1;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pfb_sfr_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pfb_port_drv_t;

endpackage

// ### rtl/pfb_sync2.sv
// Two-flop synchroniser for one pin
`timescale 1ns/100ps
module pfb_sync2
(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // Pin in, synchronised out
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_r;

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_r <= 1'b0;
      q_o    <= 1'b0;
    end
    else
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule

// ### rtl/pfb_fetch_select.sv
// Program fetch steering between original and extra port buses
`timescale 1ns/100ps
module pfb_fetch_select
(
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  // Straps
  input  wire logic                   extra_bus_select_strap_i,
  input  wire logic                   external_access_select_i,
  // Core fetch side
  input  wire logic [15:0]            fetch_addr_i,
  input  wire logic                   data_access_i,
  output logic                        mc_start_o,
  output logic [7:0]                  opcode_o,
  output logic                        opcode_valid_o,
  output logic                        fetch_extra_o,
  // Core SFR side
  input  wire pfb_pkg::pfb_sfr_req_t  sfr_req_i,
  output logic [7:0]                  sfr_rdata_o,
  output logic                        sfr_hit_o,
  // Strobes
  output logic                        ale_o,
  output logic                        program_read_strobe_n_o,
  output logic                        alt_program_read_strobe_n_o,
  // Port 5
  input  wire logic [7:0]             port5_in_i,
  output logic [7:0]                  port5_out_o,
  output logic [7:0]                  port5_oe_o,
  // Port 6
  input  wire logic [7:0]             port6_in_i,
  output logic [7:0]                  port6_out_o,
  output logic [7:0]                  port6_oe_o
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic       strap_s;
  logic       ea_s;
  logic [7:0] p5_s;
  logic [7:0] p6_s;

  pfb_sync2 u_sync_strap
  (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .d_i       (extra_bus_select_strap_i),
    .q_o       (strap_s)
  );

  pfb_sync2 u_sync_ea
  (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .d_i       (external_access_select_i),
    .q_o       (ea_s)
  );

  for (genvar g = 0; g < 8; g++)
  begin : g_sync
    pfb_sync2 u_sync_p5
    (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .d_i       (port5_in_i[g]),
      .q_o       (p5_s[g])
    );
    pfb_sync2 u_sync_p6
    (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .d_i       (port6_in_i[g]),
      .q_o       (p6_s[g])
    );
  end

  // ****************************************
  // Phase divider and machine cycle counter
  // ****************************************
  logic [3:0] div_r;
  logic [3:0] phase_r;
  logic       ph_en;

  assign ph_en      = (div_r == pfb_pkg::PHASE_DIV);
  assign mc_start_o = ph_en && (phase_r == pfb_pkg::PH_LAST);

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      div_r   <= 4'h0;
      phase_r <= 4'h0;
    end
    else
    begin
      div_r <= ph_en ? 4'h0 : div_r + 4'h1;
      if (ph_en)
        phase_r <= (phase_r == pfb_pkg::PH_LAST) ? 4'h0 : phase_r + 4'h1;
    end
  end

  // ****************************************
  // Fetch path selection
  // ****************************************
  logic bus_mode;
  logic sel_extra;
  logic sel_extra_r;
  logic dmem_r;
  logic [15:0] addr_r;

  // Strap low: extra ports stay plain I/O
  assign bus_mode  = strap_s;
  // Access pin low maps the whole space; high splits at 2000H
  assign sel_extra = bus_mode && (!ea_s || (fetch_addr_i < pfb_pkg::SPLIT_ADDR));
  assign fetch_extra_o = sel_extra_r;

  // Latch path at cycle start and before the second fetch; data-access flag once per machine cycle
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sel_extra_r <= 1'b0;
      dmem_r      <= 1'b0;
      addr_r      <= 16'h0000;
    end
    else if (mc_start_o || (ph_en && phase_r == pfb_pkg::PH_ALE2_ON - 4'h1))
    begin
      sel_extra_r <= sel_extra;
      addr_r      <= fetch_addr_i;
      if (mc_start_o)
        dmem_r <= data_access_i;
    end
  end

  // ****************************************
  // Strobe timing, shared by both buses
  // ****************************************
  logic ale_win;
  logic stb1_win;
  logic stb2_win;
  logic strobe_act;
  logic ale_r;
  logic pstb_r;
  logic astb_r;

  assign ale_win  = (phase_r >= pfb_pkg::PH_ALE1_ON && phase_r < pfb_pkg::PH_ALE1_OFF) ||
                    (!dmem_r && phase_r >= pfb_pkg::PH_ALE2_ON &&
                     phase_r < pfb_pkg::PH_ALE2_OFF);
  assign stb1_win = (phase_r >= pfb_pkg::PH_STB1_ON && phase_r < pfb_pkg::PH_STB1_OFF);
  // Second pulse dropped when the cycle carries a data access
  assign stb2_win = !dmem_r && (phase_r >= pfb_pkg::PH_STB2_ON &&
                                phase_r < pfb_pkg::PH_STB2_OFF);
  assign strobe_act = stb1_win || stb2_win;

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ale_r  <= 1'b0;
      pstb_r <= 1'b0;
      astb_r <= 1'b0;
    end
    else
    begin
      ale_r  <= ale_win;
      pstb_r <= strobe_act && !sel_extra_r;
      astb_r <= strobe_act && sel_extra_r;
    end
  end

  assign ale_o                       = ale_r;
  assign program_read_strobe_n_o     = !pstb_r;
  assign alt_program_read_strobe_n_o = !astb_r;

  // ****************************************
  // Opcode capture on port 5
  // ****************************************
  logic       op_valid_r;
  logic [7:0] op_r;
  logic       capture;

  assign capture = ph_en && sel_extra_r && astb_r &&
                   (phase_r == pfb_pkg::PH_STB1_OFF - 4'h1 ||
                    phase_r == pfb_pkg::PH_STB2_OFF - 4'h1);

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      op_r       <= 8'h00;
      op_valid_r <= 1'b0;
    end
    else
    begin
      op_valid_r <= capture;
      if (capture)
        op_r <= p5_s;
    end
  end

  assign opcode_o       = op_r;
  assign opcode_valid_o = op_valid_r;

  // ****************************************
  // Port registers, byte access only
  // ****************************************
  logic [7:0] p5_reg_r;
  logic [7:0] p6_reg_r;
  logic       hit5;
  logic       hit6;

  assign hit5      = (sfr_req_i.addr == pfb_pkg::SFR_PORT5_ADDR);
  assign hit6      = (sfr_req_i.addr == pfb_pkg::SFR_PORT6_ADDR);
  assign sfr_hit_o = hit5 || hit6;

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      p5_reg_r    <= pfb_pkg::PORT_RESET_VAL;
      p6_reg_r    <= pfb_pkg::PORT_RESET_VAL;
      sfr_rdata_o <= 8'h00;
    end
    else
    begin
      if (sfr_req_i.wr && hit5)
        p5_reg_r <= sfr_req_i.wdata;
      if (sfr_req_i.wr && hit6)
        p6_reg_r <= sfr_req_i.wdata;
      // Reads return pin levels, as on a plain port
      sfr_rdata_o <= (sfr_req_i.rd && hit5) ? p5_s :
                     (sfr_req_i.rd && hit6) ? p6_s : 8'h00;
    end
  end

  // ****************************************
  // Port drive: bus or quasi-bidirectional I/O
  // ****************************************
  logic addr_phase;
  logic [7:0] p5_out_nxt;
  logic [7:0] p5_oe_nxt;
  logic [7:0] p6_out_nxt;
  logic [7:0] p6_oe_nxt;
  logic       bus_drive;

  assign addr_phase = ale_win ||
                      (phase_r == pfb_pkg::PH_ALE1_OFF) ||
                      (phase_r == pfb_pkg::PH_ALE2_OFF);
  // Path latch already holds the strap; drive follows the strobe path
  assign bus_drive  = sel_extra_r;

  // Address low on port 5 while latched, then released for opcode
  assign p5_out_nxt = bus_drive ? addr_r[7:0] : p5_reg_r;
  assign p5_oe_nxt  = bus_drive ? {8{addr_phase}} : ~p5_reg_r;
  assign p6_out_nxt = bus_drive ? addr_r[15:8] : p6_reg_r;
  assign p6_oe_nxt  = bus_drive ? 8'hFF : ~p6_reg_r;

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      port5_out_o <= pfb_pkg::PORT_RESET_VAL;
      port5_oe_o  <= 8'h00;
      port6_out_o <= pfb_pkg::PORT_RESET_VAL;
      port6_oe_o  <= 8'h00;
    end
    else
    begin
      port5_out_o <= p5_out_nxt;
      port5_oe_o  <= p5_oe_nxt;
      port6_out_o <= p6_out_nxt;
      port6_oe_o  <= p6_oe_nxt;
    end
  end

endmodule

// ### verification/pfb_fetch_select_checker.sv
// Assertion checker for the fetch select block
`timescale 1ns/100ps
module pfb_fetch_select_checker
(
  // Clock and reset
  input wire logic                  sys_clk_i,
  input wire logic                  rst_i,
  // Watched ports
  input wire logic                  data_access_i,
  input wire pfb_pkg::pfb_sfr_req_t sfr_req_i,
  input wire logic                  mc_start_o,
  input wire logic                  fetch_extra_o,
  input wire logic                  sfr_hit_o,
  input wire logic [7:0]            sfr_rdata_o,
  input wire logic                  ale_o,
  input wire logic                  program_read_strobe_n_o,
  input wire logic                  alt_program_read_strobe_n_o,
  input wire logic [7:0]            port5_oe_o,
  input wire logic [7:0]            port6_oe_o
);
  logic [3:0] cnt_r;
  logic       alt_q_r;
  logic       da_r;
  logic       seen_r;
  wire        alt_fall = alt_q_r & ~alt_program_read_strobe_n_o;

  // Alternate strobe falls per machine cycle
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      {cnt_r, alt_q_r, da_r, seen_r} <= {4'h0, 3'h4};
    else
    begin
      alt_q_r <= alt_program_read_strobe_n_o;
      cnt_r   <= mc_start_o ? 4'h0 : cnt_r + {3'h0, alt_fall};
      da_r    <= mc_start_o ? data_access_i : da_r;
      seen_r  <= seen_r | mc_start_o;
    end

  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  property p_alt_max;
    mc_start_o && seen_r |-> cnt_r <= 4'h2;
  endproperty
  a_alt_max: assert property (p_alt_max) else $error("too many strobes");
  property p_alt_skip;
    mc_start_o && seen_r && da_r |-> cnt_r <= 4'h1;
  endproperty
  a_alt_skip: assert property (p_alt_skip) else $error("second strobe kept");
  property p_alt_path;
    !alt_program_read_strobe_n_o |-> fetch_extra_o && port5_oe_o == 8'h00;
  endproperty
  a_alt_path: assert property (p_alt_path) else $error("bad alt strobe");
  property p_std_path;
    !program_read_strobe_n_o |-> !fetch_extra_o && alt_program_read_strobe_n_o;
  endproperty
  a_std_path: assert property (p_std_path) else $error("bad std strobe");
  property p_addr_drive;
    ale_o && fetch_extra_o |-> port5_oe_o == 8'hFF && port6_oe_o == 8'hFF;
  endproperty
  a_addr_drive: assert property (p_addr_drive) else $error("address not driven");
  property p_unmapped;
    sfr_req_i.rd && !sfr_hit_o |=> sfr_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read data");
  property p_alt_width;
    $fell(alt_program_read_strobe_n_o) |=> !alt_program_read_strobe_n_o[*3] ##1
      alt_program_read_strobe_n_o;
  endproperty
  a_alt_width: assert property (p_alt_width) else $error("alt strobe width");
  property p_std_width;
    $fell(program_read_strobe_n_o) |=> !program_read_strobe_n_o[*3] ##1 program_read_strobe_n_o;
  endproperty
  a_std_width: assert property (p_std_width) else $error("std strobe width");
endmodule

bind pfb_fetch_select pfb_fetch_select_checker u_pfb_fetch_select_checker
(
  .sys_clk_i, .rst_i, .data_access_i, .sfr_req_i, .mc_start_o, .fetch_extra_o, .sfr_hit_o,
  .sfr_rdata_o, .ale_o, .program_read_strobe_n_o, .alt_program_read_strobe_n_o,
  .port5_oe_o, .port6_oe_o
);

// ### verification/pfb_eprom_model.sv
// External program memory with address latch
`timescale 1ns/100ps
module pfb_eprom_model
(
  // Strobes
  input  wire logic       ale_i,
  input  wire logic       strobe_n_i,
  // Pins
  input  wire logic [7:0] p5_out_i,
  input  wire logic [7:0] p5_oe_i,
  input  wire logic [7:0] p6_out_i,
  input  wire logic [7:0] p6_oe_i,
  output logic      [7:0] p5_pin_o,
  output logic      [7:0] p6_pin_o
);
  logic [7:0] lo_r = 8'h00;
  // Pull-ups hold undriven bits high
  wire  [7:0] p5_bus = p5_oe_i & p5_out_i | ~p5_oe_i;

  // Capture 20 ns after the rising edge, clear of edge races
  always @(posedge ale_i)
    #20 lo_r = p5_bus;
  assign p6_pin_o = p6_oe_i & p6_out_i | ~p6_oe_i;
  assign p5_pin_o = strobe_n_i ? p5_bus : lo_r ^ p6_pin_o ^ 8'h5A;
endmodule

// ### verification/test_program_fetch_bus_select.sv
// Testbench for the fetch select block
`timescale 1ns/100ps
module test_program_fetch_bus_select;
  logic                  sys_clk_i = 1'b0;
  logic                  rst_i = 1'b1;
  logic                  extra_bus_select_strap_i = 1'b0;
  logic                  external_access_select_i = 1'b0;
  logic                  data_access_i = 1'b0;
  logic [15:0]           fetch_addr_i = 16'h0000;
  pfb_pkg::pfb_sfr_req_t sfr_req_i = '0;
  logic                  mc_start_o, opcode_valid_o, fetch_extra_o, sfr_hit_o, ale_o;
  logic                  program_read_strobe_n_o, alt_program_read_strobe_n_o;
  logic [7:0]            opcode_o, sfr_rdata_o, port5_out_o, port5_oe_o, port5_in_i;
  logic [7:0]            port6_out_o, port6_oe_o, port6_in_i;
  logic                  alt_q = 1'b1;
  logic                  std_q = 1'b1;
  bit                    op_en = 1'b0;
  int                    failures = 0;
  int                    tests_run = 0;
  int                    cyc = 0;
  int                    na = 0;
  int                    np = 0;
  int                    nv = 0;
  wire  [7:0]            exp_op = fetch_addr_i[7:0] ^ fetch_addr_i[15:8] ^ 8'h5A;

  always #20 sys_clk_i = ~sys_clk_i;

  pfb_fetch_select u_pfb_fetch_select
  (
    .sys_clk_i, .rst_i, .extra_bus_select_strap_i, .external_access_select_i, .fetch_addr_i,
    .data_access_i, .mc_start_o, .opcode_o, .opcode_valid_o, .fetch_extra_o, .sfr_req_i,
    .sfr_rdata_o, .sfr_hit_o, .ale_o, .program_read_strobe_n_o, .alt_program_read_strobe_n_o,
    .port5_in_i, .port5_out_o, .port5_oe_o, .port6_in_i, .port6_out_o, .port6_oe_o
  );
  pfb_eprom_model u_pfb_eprom_model
  (
    .ale_i(ale_o), .strobe_n_i(alt_program_read_strobe_n_o), .p5_out_i(port5_out_o),
    .p5_oe_i(port5_oe_o), .p6_out_i(port6_out_o), .p6_oe_i(port6_oe_o),
    .p5_pin_o(port5_in_i), .p6_pin_o(port6_in_i)
  );

  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    sfr_req_i = {w, ~w, a, d};
    @(negedge sys_clk_i);
    sfr_req_i = '0;
    if (!w)
      chk("sfr_rdata", 16'h0000, {8'h00, sfr_rdata_o ^ d});
    repeat (4) @(negedge sys_clk_i);
  endtask

  task automatic wait_mc;
    do
      @(negedge sys_clk_i);
    while (mc_start_o !== 1'b1);
  endtask

  task automatic run(input logic s, x, d, input logic [15:0] a, input int ea, ep);
    {extra_bus_select_strap_i, external_access_select_i, data_access_i} = {s, x & s, d};
    fetch_addr_i = a;
    repeat (3) wait_mc;
    {na, np, nv, op_en} = {32'd0, 32'd0, 32'd0, 1'b1};
    repeat (2) wait_mc;
    op_en = 1'b0;
    chk("alt_strobe_falls", 16'(ea), 16'(na));
    chk("std_strobe_falls", 16'(ep), 16'(np));
    chk("opcode_valids", 16'(ea), 16'(nv));
    $display("Test done: strap %b access %b data %b addr %h", s, x, d, a);
  endtask

  // Strobe counting, opcode check, timeout
  always @(negedge sys_clk_i)
  begin
    cyc++;
    na += int'(alt_q && !alt_program_read_strobe_n_o);
    np += int'(std_q && !program_read_strobe_n_o);
    nv += int'(opcode_valid_o === 1'b1);
    alt_q = alt_program_read_strobe_n_o;
    std_q = program_read_strobe_n_o;
    if (op_en && opcode_valid_o === 1'b1 && fetch_extra_o === 1'b1)
      chk("opcode", {8'h00, exp_op}, {8'h00, opcode_o});
    if (cyc == 3000)
    begin
      failures++;
      end_of_test;
    end
  end

  initial
  begin
    repeat (4) @(negedge sys_clk_i);
    rst_i = 1'b0;
    run(0, 0, 0, 16'h1234, 0, 4);
    run(0, 0, 1, 16'h0040, 0, 2);
    sfr(1, 8'h91, 8'h3C);
    sfr(0, 8'h91, 8'h3C);
    sfr(1, 8'hA1, 8'hC3);
    sfr(0, 8'hA1, 8'hC3);
    sfr(1, 8'h90, 8'h55);
    sfr(0, 8'h90, 8'h00);
    sfr(0, 8'h91, 8'h3C);
    $display("Test done: port registers");
    run(1, 0, 0, 16'h1234, 4, 0);
    run(1, 0, 1, 16'hBEEF, 2, 0);
    run(1, 1, 0, 16'h1FFF, 4, 0);
    run(1, 1, 0, 16'h2000, 0, 4);
    end_of_test;
  end
endmodule
